// *** design/icplc_defines.svh ***
// constants of the configuration port and regulator control block
`ifndef ICPLC_DEFINES_SVH
`define ICPLC_DEFINES_SVH

// -----------------------------------------------------------------
// bus address and register map
// -----------------------------------------------------------------
`define ICPLC_SLAVE_ADDR 7'h38
`define ICPLC_NUM_REGS 5
`define ICPLC_REG_CFG 8'h00
`define ICPLC_REG_STATUS 8'h05
`define ICPLC_REGS_RESET 40'h0606060644
`define ICPLC_CFG_RESET 8'h44
`define ICPLC_CFG_MASK 8'h7F
`define ICPLC_CLK_MASK 8'h3F

// -----------------------------------------------------------------
// configuration fields
// -----------------------------------------------------------------
`define ICPLC_MODE_MSB 6
`define ICPLC_MODE_LSB 5
`define ICPLC_MODE_OFF 2'h0
`define ICPLC_MODE_TRACK 2'h2
`define ICPLC_MODE_FORCE 2'h3
`define ICPLC_STATUS_OVH_BIT 0

// -----------------------------------------------------------------
// byte framing
// -----------------------------------------------------------------
`define ICPLC_BIT_LAST 4'h7
`define ICPLC_BIT_ACK 4'h8
`define ICPLC_BIT_SKIP 4'hF

`endif

// *** design/icplc_pkg.sv ***
// types of the configuration port and regulator control block
package icplc_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_WDATA,
		ST_RDATA,
		ST_IGNORE
	} icplc_link_st_type;

	typedef logic [4:0][7:0] icplc_regs_type;

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		logic ovh_s1;
		logic ovh_s2;
		icplc_link_st_type st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic [7:0] ptr;
		logic rw;
		logic busy;
		logic sda_out;
		logic sda_oe_n;
		icplc_regs_type regs;
		logic wr_tgl;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic rd_tgl;
	} icplc_link_type;

	typedef struct packed {
		logic [3:0] req_s1;
		logic [3:0] req_s2;
		logic en_s1;
		logic en_s2;
		logic ot_s1;
		logic ot_s2;
		logic wr_s1;
		logic wr_s2;
		logic wr_s3;
		logic rd_s1;
		logic rd_s2;
		logic rd_s3;
		logic [7:0] cfg;
		logic ovh;
		logic ldo_en;
		logic rail_ldo;
		logic rail_en;
	} icplc_core_type;

endpackage : icplc_pkg

// *** design/icplc_top.sv ***
// two-wire configuration slave and regulator control
`timescale 1ns/1ns
`include "icplc_defines.svh"

module icplc_top (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic [3:0] peripheral_clock_request_in_i,
	input wire logic enable_i,
	input wire logic overtemp_i,
	output logic ldo_en_o,
	output logic request_logic_rail_from_ldo_o,
	output logic request_logic_rail_from_enable_o,
	output logic shutdown_o,
	output logic [7:0] config_o,
	output logic bus_busy_o
);
	import icplc_pkg::*;

	icplc_link_type lk_q;
	icplc_link_type lk_d;
	icplc_core_type co_q;
	icplc_core_type co_d;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic addr_hit;
	logic wr_evt;
	logic rd_evt;
	logic [1:0] mode;

	// status register is read-only; unmapped pointers read as zero
	function automatic logic [7:0] reg_read(input icplc_regs_type regs,
			input logic [7:0] ptr, input logic ovh);
		logic [7:0] r;
		r = 8'h00;
		if (ptr < 8'(`ICPLC_NUM_REGS))
		begin
			r = regs[ptr[2:0]];
		end
		else if (ptr == `ICPLC_REG_STATUS)
		begin
			r[`ICPLC_STATUS_OVH_BIT] = ovh;
		end
		return r;
	endfunction : reg_read

	// -----------------------------------------------------------------
	// link domain: bus framing and register file
	// -----------------------------------------------------------------
	assign scl_rise = lk_q.scl_s2 & ~lk_q.scl_d;
	assign scl_fall = ~lk_q.scl_s2 & lk_q.scl_d;
	assign start_c = lk_q.scl_s2 & lk_q.scl_d & lk_q.sda_d & ~lk_q.sda_s2;
	assign stop_c = lk_q.scl_s2 & lk_q.scl_d & ~lk_q.sda_d & lk_q.sda_s2;
	assign addr_hit = (lk_q.sh[7:1] == `ICPLC_SLAVE_ADDR);

	always_comb
	begin
		lk_d = lk_q;
		lk_d.scl_s1 = scl_i;
		lk_d.scl_s2 = lk_q.scl_s1;
		lk_d.scl_d = lk_q.scl_s2;
		lk_d.sda_s1 = sda_i;
		lk_d.sda_s2 = lk_q.sda_s1;
		lk_d.sda_d = lk_q.sda_s2;
		lk_d.ovh_s1 = co_q.ovh;
		lk_d.ovh_s2 = lk_q.ovh_s1;
		if (start_c)
		begin
			// a repeated start is the same as a first start
			lk_d.st = ST_ADDR;
			lk_d.cnt = `ICPLC_BIT_SKIP;
			lk_d.busy = 1'b1;
			lk_d.sda_oe_n = 1'b1;
		end
		else if (stop_c)
		begin
			lk_d.st = ST_IDLE;
			lk_d.busy = 1'b0;
			lk_d.sda_oe_n = 1'b1;
		end
		else if (lk_q.st != ST_IDLE && lk_q.st != ST_IGNORE)
		begin
			if (scl_rise)
			begin
				if (lk_q.cnt < `ICPLC_BIT_ACK)
				begin
					lk_d.sh = {lk_q.sh[6:0], lk_q.sda_s2};
				end
				else if (lk_q.st == ST_WDATA)
				begin
					// commit on the rise of our own acknowledge
					if (lk_q.ptr < 8'(`ICPLC_NUM_REGS))
					begin
						lk_d.wr_addr = lk_q.ptr;
						lk_d.wr_data = lk_q.sh & ((lk_q.ptr == `ICPLC_REG_CFG) ?
							`ICPLC_CFG_MASK : `ICPLC_CLK_MASK);
						lk_d.regs[lk_q.ptr[2:0]] = lk_d.wr_data;
						lk_d.wr_tgl = ~lk_q.wr_tgl;
					end
					lk_d.ptr = lk_q.ptr + 8'h01;
				end
				else if (lk_q.st == ST_RDATA && lk_q.sda_s2)
				begin
					lk_d.st = ST_IGNORE; // host said no more
				end
			end
			else if (scl_fall)
			begin
				// data line only moves while the clock is low
				if (lk_q.cnt == `ICPLC_BIT_SKIP)
				begin
					// the fall that closes a start is no data bit
					lk_d.cnt = 4'h0;
				end
				else if (lk_q.cnt < `ICPLC_BIT_LAST)
				begin
					lk_d.cnt = lk_q.cnt + 4'h1;
					if (lk_q.st == ST_RDATA)
					begin
						lk_d.tx = {lk_q.tx[6:0], 1'b0};
						lk_d.sda_oe_n = lk_q.tx[6];
					end
				end
				else if (lk_q.cnt == `ICPLC_BIT_LAST)
				begin
					lk_d.cnt = `ICPLC_BIT_ACK;
					unique case (lk_q.st)
						ST_ADDR:
						begin
							if (addr_hit)
							begin
								lk_d.sda_oe_n = 1'b0;
								lk_d.rw = lk_q.sh[0];
							end
							else
							begin
								lk_d.st = ST_IGNORE;
							end
						end
						ST_PTR, ST_WDATA:
						begin
							lk_d.sda_oe_n = 1'b0;
						end
						ST_RDATA:
						begin
							lk_d.sda_oe_n = 1'b1;
						end
						ST_IDLE, ST_IGNORE:
						begin
							lk_d.sda_oe_n = 1'b1;
						end
					endcase
				end
				else
				begin
					lk_d.cnt = 4'h0;
					lk_d.sda_oe_n = 1'b1;
					if (lk_q.st == ST_PTR)
					begin
						lk_d.ptr = lk_q.sh;
						lk_d.st = ST_WDATA;
					end
					else if ((lk_q.st == ST_ADDR && lk_q.rw) ||
							lk_q.st == ST_RDATA)
					begin
						// reads use the pointer left by a prior write
						lk_d.st = ST_RDATA;
						lk_d.tx = reg_read(lk_q.regs, lk_q.ptr, lk_q.ovh_s2);
						lk_d.sda_oe_n = lk_d.tx[7];
						lk_d.ptr = lk_q.ptr + 8'h01;
						if (lk_q.ptr == `ICPLC_REG_STATUS)
						begin
							lk_d.rd_tgl = ~lk_q.rd_tgl;
						end
					end
					else if (lk_q.st == ST_ADDR)
					begin
						lk_d.st = ST_PTR;
					end
				end
			end
		end
	end

	always_ff @(posedge link_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			lk_q <= '0;
			lk_q.scl_s1 <= 1'b1;
			lk_q.scl_s2 <= 1'b1;
			lk_q.scl_d <= 1'b1;
			lk_q.sda_s1 <= 1'b1;
			lk_q.sda_s2 <= 1'b1;
			lk_q.sda_d <= 1'b1;
			lk_q.st <= ST_IDLE;
			lk_q.sda_oe_n <= 1'b1;
			lk_q.regs <= `ICPLC_REGS_RESET;
		end
		else
		begin
			lk_q <= lk_d;
		end
	end

	a_start_restart: assert property (@(posedge link_clk_i)
		disable iff (!rstn_i) start_c |=> lk_q.st == ST_ADDR &&
		lk_q.cnt == `ICPLC_BIT_SKIP && lk_q.busy)
		else $error("start did not restart address reception");

	a_stop_frees: assert property (@(posedge link_clk_i)
		disable iff (!rstn_i) stop_c |=> !lk_q.busy && lk_q.sda_oe_n &&
		lk_q.st == ST_IDLE)
		else $error("stop did not free the bus");

	a_addr_ack: assert property (@(posedge link_clk_i)
		disable iff (!rstn_i) (lk_q.st == ST_ADDR && scl_fall &&
		lk_q.cnt == `ICPLC_BIT_LAST && addr_hit && !start_c && !stop_c)
		|=> !lk_q.sda_oe_n)
		else $error("own address not acknowledged");

	a_addr_nack: assert property (@(posedge link_clk_i)
		disable iff (!rstn_i) (lk_q.st == ST_ADDR && scl_fall &&
		lk_q.cnt == `ICPLC_BIT_LAST && !addr_hit && !start_c && !stop_c)
		|=> lk_q.st == ST_IGNORE && lk_q.sda_oe_n
		until (start_c || stop_c))
		else $error("foreign address was answered");

	a_sda_low_clk: assert property (@(posedge link_clk_i)
		disable iff (!rstn_i) ($changed(lk_q.sda_oe_n) &&
		!$past(start_c) && !$past(stop_c)) |-> !$past(lk_q.scl_s2))
		else $error("data line moved while clock high");

	a_write_commit: assert property (@(posedge link_clk_i)
		disable iff (!rstn_i) (lk_q.st == ST_WDATA && scl_rise &&
		lk_q.cnt == `ICPLC_BIT_ACK && lk_q.ptr == `ICPLC_REG_CFG &&
		!start_c && !stop_c) |=> lk_q.regs[0] ==
		($past(lk_q.sh) & `ICPLC_CFG_MASK) && $changed(lk_q.wr_tgl))
		else $error("written value not committed at acknowledge");

	a_rx_ack_all: assert property (@(posedge link_clk_i)
		disable iff (!rstn_i) ((lk_q.st == ST_PTR || lk_q.st == ST_WDATA)
		&& scl_fall && lk_q.cnt == `ICPLC_BIT_LAST && !start_c && !stop_c)
		|=> !lk_q.sda_oe_n)
		else $error("received byte not acknowledged");

	// -----------------------------------------------------------------
	// core domain: regulator control and overheat flag
	// -----------------------------------------------------------------
	assign wr_evt = co_q.wr_s2 ^ co_q.wr_s3;
	assign rd_evt = co_q.rd_s2 ^ co_q.rd_s3;
	assign mode = co_q.cfg[`ICPLC_MODE_MSB:`ICPLC_MODE_LSB];

	always_comb
	begin
		co_d = co_q;
		co_d.req_s1 = peripheral_clock_request_in_i;
		co_d.req_s2 = co_q.req_s1;
		co_d.en_s1 = enable_i;
		co_d.en_s2 = co_q.en_s1;
		co_d.ot_s1 = overtemp_i;
		co_d.ot_s2 = co_q.ot_s1;
		co_d.wr_s1 = lk_q.wr_tgl;
		co_d.wr_s2 = co_q.wr_s1;
		co_d.wr_s3 = co_q.wr_s2;
		co_d.rd_s1 = lk_q.rd_tgl;
		co_d.rd_s2 = co_q.rd_s1;
		co_d.rd_s3 = co_q.rd_s2;
		// address and data stand still long after the toggle moves
		if (wr_evt && lk_q.wr_addr == `ICPLC_REG_CFG)
		begin
			co_d.cfg = lk_q.wr_data;
		end
		// a new overtemperature wins over a clear by status read
		co_d.ovh = co_q.ot_s2 | (co_q.ovh & ~rd_evt);
		co_d.ldo_en = ~co_q.ovh & ((mode == `ICPLC_MODE_FORCE) |
			((mode == `ICPLC_MODE_TRACK) & (|co_q.req_s2)));
		co_d.rail_ldo = co_d.ldo_en;
		co_d.rail_en = ~co_d.ldo_en & co_q.en_s2;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			co_q <= '0;
			co_q.cfg <= `ICPLC_CFG_RESET;
		end
		else
		begin
			co_q <= co_d;
		end
	end

	a_track_req: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i) (mode == `ICPLC_MODE_TRACK && !co_q.ovh)
		|=> ldo_en_o == $past(|co_q.req_s2))
		else $error("regulator does not follow requests");

	a_force_on: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i) (mode == `ICPLC_MODE_FORCE && !co_q.ovh)
		[*2] |=> ldo_en_o && request_logic_rail_from_ldo_o)
		else $error("forced regulator not on");

	a_mode_off: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i) (mode == `ICPLC_MODE_OFF) |=> !ldo_en_o)
		else $error("regulator on in off mode");

	a_rail_enable: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i) !ldo_en_o |-> request_logic_rail_from_enable_o
		== co_q.en_s2 || $changed(co_q.en_s2))
		else $error("rail not fed from enable");

	a_overheat: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i) co_q.ot_s2 |=> shutdown_o ##1 !ldo_en_o)
		else $error("overheat did not shut down");

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign sda_o = lk_q.sda_out;
	assign sda_oe_n_o = lk_q.sda_oe_n;
	assign bus_busy_o = lk_q.busy;
	assign ldo_en_o = co_q.ldo_en;
	assign request_logic_rail_from_ldo_o = co_q.rail_ldo;
	assign request_logic_rail_from_enable_o = co_q.rail_en;
	assign shutdown_o = co_q.ovh;
	assign config_o = co_q.cfg;

endmodule : icplc_top

// *** design/placeholder_unused.sv ***
// intentionally empty compile unit
`timescale 1ns/1ns

// *** test/icplc_host_model.sv ***
// two-wire bus host model driving the configuration port
`timescale 1ns/1ns
module icplc_host_model (
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	// quarter bit period; long against the slave's sync lag
	localparam int QTR = 300;
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// --------------------------------------------------------------
	// conditions and bits
	// --------------------------------------------------------------
	// also serves as repeated start: entered with clock low
	task start;
		sda_o = 1'b1;
		#QTR scl_o = 1'b1;
		#QTR sda_o = 1'b0;
		#QTR scl_o = 1'b0;
		#QTR;
	endtask : start
	task stop;
		sda_o = 1'b0;
		#QTR scl_o = 1'b1;
		#QTR sda_o = 1'b1;
		#QTR;
	endtask : stop
	task bitx(input logic b, output logic r);
		sda_o = b;
		#QTR scl_o = 1'b1;
		#QTR r = sda_i;
		#QTR scl_o = 1'b0;
		#QTR;
	endtask : bitx
	task wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask : wbyte
	task rbyte(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(!ack, r);
	endtask : rbyte
endmodule : icplc_host_model

// *** test/tb.sv ***
// self-checking bench of the configuration port and regulator
`timescale 1ns/1ns
module tb;
	logic core_clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [3:0] req_q = 4'h0;
	logic en_q = 1'b1;
	logic ot_q = 1'b0;
	logic a;
	logic [7:0] d;
	wire host_scl;
	wire host_sda;
	wire dev_sda;
	wire dev_oe_n;
	// open drain with pull-up: low if either party pulls
	wire sda_line = host_sda & (dev_oe_n | dev_sda);
	wire ldo_en;
	wire rail_ldo;
	wire rail_en;
	wire shutdown;
	wire busy;
	wire [7:0] cfg;
	int n_mismatch = 0;
	int n_compared = 0;
	initial
		forever #10 core_clk_i = !core_clk_i;
	initial
	begin
		#7;
		forever #15 link_clk_i = !link_clk_i;
	end
	icplc_host_model host (.scl_o(host_scl), .sda_o(host_sda),
		.sda_i(sda_line));
	icplc_top uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.link_clk_i(link_clk_i), .scl_i(host_scl), .sda_i(sda_line),
		.sda_o(dev_sda), .sda_oe_n_o(dev_oe_n),
		.peripheral_clock_request_in_i(req_q), .enable_i(en_q),
		.overtemp_i(ot_q), .ldo_en_o(ldo_en),
		.request_logic_rail_from_ldo_o(rail_ldo),
		.request_logic_rail_from_enable_o(rail_en),
		.shutdown_o(shutdown), .config_o(cfg), .bus_busy_o(busy));
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk
	task settle;
		repeat (8) @(negedge core_clk_i);
	endtask : settle
	task drive(input logic [3:0] r, input logic o);
		@(posedge core_clk_i);
		req_q <= r;
		ot_q <= o;
		settle;
	endtask : drive
	task wr(input logic [7:0] ptr, input logic [7:0] val);
		host.start;
		chk({7'h0, busy}, 8'h01);
		host.wbyte(8'h70, a);
		chk({7'h0, a}, 8'h01);
		host.wbyte(ptr, a);
		chk({7'h0, a}, 8'h01);
		host.wbyte(val, a);
		chk({7'h0, a}, 8'h01);
		host.stop;
		chk({7'h0, busy}, 8'h00);
		settle;
	endtask : wr
	// pointer write first, then repeated start and read
	task rd(input logic [7:0] ptr, output logic [7:0] val);
		host.start;
		host.wbyte(8'h70, a);
		host.wbyte(ptr, a);
		host.start;
		host.wbyte(8'h71, a);
		chk({7'h0, a}, 8'h01);
		host.rbyte(val, 1'b0);
		host.stop;
		settle;
	endtask : rd
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task t_reset;
		chk(cfg, 8'h44);
		chk({7'h0, ldo_en}, 8'h00);
		chk({7'h0, rail_en}, 8'h01);
	endtask : t_reset
	task t_track;
		drive(4'h8, 1'b0);
		chk({6'h0, ldo_en, rail_ldo}, 8'h03);
		chk({7'h0, rail_en}, 8'h00);
		drive(4'h0, 1'b0);
		chk({6'h0, ldo_en, rail_en}, 8'h01);
	endtask : t_track
	task t_modes;
		logic [1:0] m;
		for (int i = 0; i < 4; i++)
		begin
			m = i[1:0];
			wr(8'h00, {1'b0, m, 5'h04});
			chk(cfg, {1'b0, m, 5'h04});
			chk({7'h0, ldo_en}, {7'h0, m == 2'h3});
			drive(4'h1, 1'b0);
			chk({7'h0, ldo_en}, {7'h0, m[1]});
			drive(4'h0, 1'b0);
		end
		wr(8'h00, 8'h44);
	endtask : t_modes
	task t_read;
		rd(8'h00, d);
		chk(d, 8'h44);
	endtask : t_read
	// address 39h: ignored bytes must not reach the register
	task t_wrong;
		host.start;
		host.wbyte(8'h72, a);
		chk({7'h0, a}, 8'h00);
		host.wbyte(8'h00, a);
		chk({7'h0, a}, 8'h00);
		host.wbyte(8'h60, a);
		host.stop;
		settle;
		chk(cfg, 8'h44);
	endtask : t_wrong
	// flag stays after the cause goes; a status read clears it
	task t_heat;
		drive(4'h1, 1'b1);
		chk({6'h0, shutdown, ldo_en}, 8'h02);
		drive(4'h1, 1'b0);
		chk({6'h0, shutdown, ldo_en}, 8'h02);
		rd(8'h05, d);
		chk({7'h0, d[0]}, 8'h01);
		chk({6'h0, shutdown, ldo_en}, 8'h01);
	endtask : t_heat
	// --------------------------------------------------------------
	// sequence and verdict
	// --------------------------------------------------------------
	task report_and_stop;
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (5) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		t_reset;
		t_track;
		t_modes;
		t_read;
		t_wrong;
		t_heat;
		report_and_stop;
	end
	// eight transfers of under 50 us each; 1 ms is ample
	initial
	begin
		#1000000;
		n_mismatch++;
		report_and_stop;
	end
endmodule : tb
